//--- hw/bsf_top.sv
// Boot outcome status register: sticky boot flags, read over a byte port
// =====================================================
`default_nettype none
module bsf_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [2:0] reg_byte_sel,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_err,
  input wire logic [7:0] revision_id,
  input wire logic src_valid,
  input wire bsf_pkg::bsf_src_type src_code,
  input wire logic thermal_shutdown_reboot,
  input wire logic r1_crc_fail,
  input wire logic r0_crc_fail,
  input wire logic patch_dl_error,
  input wire logic r1_read_error,
  input wire logic r0_read_error,
  input wire logic r1_header_invalid,
  input wire logic r0_header_invalid,
  input wire logic r1_attempted,
  input wire logic r0_attempted,
  input wire logic eeprom_present,
  input wire logic dead_battery_boot,
  input wire logic patch_header_error,
  output logic [39:0] status_q
);
  import bsf_pkg::*;

  // =====================================================
  // Event capture
  // Events come from boot logic on ref_clk, so no synchroniser is needed.
  localparam int NFLAG = 13;
  logic [NFLAG-1:0] ev;
  logic [NFLAG-1:0] fl;
  assign ev = {thermal_shutdown_reboot, r1_crc_fail, r0_crc_fail, patch_dl_error,
               r1_read_error, r0_read_error, r1_header_invalid, r0_header_invalid,
               r1_attempted, r0_attempted, eeprom_present, dead_battery_boot,
               patch_header_error};

  genvar gi;
  generate
    for (gi = 0; gi < NFLAG; gi++) begin : g_flag
      // Sticky: a later successful retry never clears a read error
      bsf_sticky u_flag (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .set_i(ev[gi]),
        .flag_q(fl[gi])
      );
    end
  endgenerate

  // =====================================================
  // Revision and patch source
  logic [7:0] rev_q;
  bsf_src_type src_q;
  logic rev_done_q;

  // Revision sampled after reset release, then held
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rev_q <= 8'h00;
      rev_done_q <= 1'b0;
    end else if (!rev_done_q) begin
      rev_q <= revision_id;
      rev_done_q <= 1'b1;
    end
  end

  // Reserved codes are dropped so the field only shows a documented source
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_q <= BSF_SRC_NONE;
    end else if (src_valid) begin
      unique case (src_code)
        BSF_SRC_NONE, BSF_SRC_EEPROM, BSF_SRC_I2C: src_q <= src_code;
        default: src_q <= src_q;
      endcase
    end
  end

  // =====================================================
  // Register image
  logic [39:0] image;
  always_comb begin
    image = BSF_STATUS_RST;
    image[BSF_REV_LSB +: 8] = rev_q;
    image[BSF_SRC_LSB +: 3] = src_q;
    image[BSF_TSD_BIT] = fl[12];
    image[BSF_R1_CRC_BIT] = fl[11];
    image[BSF_R0_CRC_BIT] = fl[10];
    image[BSF_DL_ERR_BIT] = fl[9];
    image[BSF_R1_RDERR_BIT] = fl[8];
    image[BSF_R0_RDERR_BIT] = fl[7];
    image[BSF_R1_INV_BIT] = fl[6];
    image[BSF_R0_INV_BIT] = fl[5];
    image[BSF_R1_ATT_BIT] = fl[4];
    image[BSF_R0_ATT_BIT] = fl[3];
    image[BSF_PRES_BIT] = fl[2];
    image[BSF_DB_BIT] = fl[1];
    image[BSF_HDR_ERR_BIT] = fl[0];
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= BSF_STATUS_RST;
    end else begin
      status_q <= image;
    end
  end

  // =====================================================
  // Register port
  // Byte select picks one of five bytes; out of range reads zero with error
  logic hit;
  assign hit = (reg_addr == BSF_ADDR_STATUS) && (reg_byte_sel < BSF_SEL_W);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && hit) begin
      reg_rdata <= image[{reg_byte_sel, 3'h0} +: 8];
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Writes are accepted but ignored; error flags miss and write attempts
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_err <= 1'b0;
    end else begin
      reg_err <= (reg_rd && !hit) || reg_wr;
    end
  end

  logic unused_wdata;
  assign unused_wdata = ^reg_wdata;
endmodule : bsf_top
`default_nettype wire

//--- hw/bsf_pkg.sv
// Package of constants for the boot outcome status register block
`default_nettype none
package bsf_pkg;
  // =====================================================
  // Register map
  localparam logic [7:0] BSF_ADDR_STATUS = 8'h2D;
  localparam int BSF_REG_W = 40;
  localparam logic [39:0] BSF_STATUS_RST = 40'h00_0000_0000;
  localparam int BSF_BUS_W = 8;
  localparam int BSF_BYTES = 5;
  localparam logic [2:0] BSF_SEL_W = 3'h5;
  // =====================================================
  // Field positions
  localparam int BSF_REV_LSB = 32;
  localparam int BSF_SRC_LSB = 29;
  localparam int BSF_TSD_BIT = 19;
  localparam int BSF_R1_CRC_BIT = 13;
  localparam int BSF_R0_CRC_BIT = 12;
  localparam int BSF_DL_ERR_BIT = 10;
  localparam int BSF_R1_RDERR_BIT = 9;
  localparam int BSF_R0_RDERR_BIT = 8;
  localparam int BSF_R1_INV_BIT = 7;
  localparam int BSF_R0_INV_BIT = 6;
  localparam int BSF_R1_ATT_BIT = 5;
  localparam int BSF_R0_ATT_BIT = 4;
  localparam int BSF_PRES_BIT = 3;
  localparam int BSF_DB_BIT = 2;
  localparam int BSF_HDR_ERR_BIT = 0;
  // =====================================================
  // Patch source codes
  typedef enum logic [2:0] {
    BSF_SRC_NONE = 3'h0,
    BSF_SRC_EEPROM = 3'h5,
    BSF_SRC_I2C = 3'h6
  } bsf_src_type;
endpackage : bsf_pkg
`default_nettype wire

//--- hw/bsf_sticky.sv
// Sticky flag cell: set by an event, cleared only by reset
`default_nettype none
module bsf_sticky (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic set_i,
  output logic flag_q
);
  // =====================================================
  // Flag store
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else if (set_i) begin
      flag_q <= 1'b1;
    end
  end
endmodule : bsf_sticky
`default_nettype wire

//--- testbench/bsf_chk.sv
// Port checker for the boot outcome status register
`default_nettype none
module bsf_chk (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [2:0] reg_byte_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_err,
  input wire logic src_valid,
  input wire bsf_pkg::bsf_src_type src_code,
  input wire logic thermal_shutdown_reboot,
  input wire logic r1_crc_fail,
  input wire logic r0_crc_fail,
  input wire logic [39:0] status_q
);
  import bsf_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // =============================
  // Properties
  property p_tsd; thermal_shutdown_reboot |-> ##2 status_q[19]; endproperty
  a_tsd: assert property (p_tsd) else $error("tsd flag");
  property p_c1; r1_crc_fail |-> ##2 status_q[13]; endproperty
  a_c1: assert property (p_c1) else $error("crc1 flag");
  property p_c0; r0_crc_fail |-> ##2 status_q[12]; endproperty
  a_c0: assert property (p_c0) else $error("crc0 flag");
  property p_keep; status_q[8] |=> status_q[8]; endproperty
  a_keep: assert property (p_keep) else $error("flag lost");
  property p_src; src_valid && src_code == BSF_SRC_I2C |-> ##2 status_q[31:29] == 3'h6; endproperty
  a_src: assert property (p_src) else $error("source");
  property p_res;
    status_q[28:20] == 9'h000 && status_q[18:14] == 5'h00 && !status_q[11] && !status_q[1];
  endproperty
  a_res: assert property (p_res) else $error("reserved");
  property p_wr; reg_wr |=> reg_err && reg_rdata == 8'h00; endproperty
  a_wr: assert property (p_wr) else $error("write");
  property p_unm; reg_rd && reg_addr != BSF_ADDR_STATUS |=> reg_err && reg_rdata == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped");
  property p_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("idle data");
  c_ev: cover property (r0_crc_fail);
  c_wr: cover property (reg_wr);
  c_src: cover property (src_valid);
endmodule : bsf_chk
bind bsf_top bsf_chk u_bsf_chk (.ref_clk, .rst_n, .reg_addr, .reg_byte_sel, .reg_wr, .reg_rd,
  .reg_rdata, .reg_err, .src_valid, .src_code, .thermal_shutdown_reboot, .r1_crc_fail,
  .r0_crc_fail, .status_q);
`default_nettype wire

//--- testbench/bsf_top_tb_top.sv
// Testbench of the boot outcome status register
`default_nettype none
module bsf_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import bsf_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [2:0] reg_byte_sel = 3'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic src_valid = 1'b0;
  bsf_src_type src_code = BSF_SRC_NONE;
  logic [12:0] ev = 13'h0000;
  logic [7:0] reg_rdata;
  logic reg_err;
  logic [39:0] status_q;
  logic [39:0] exp_q;
  int mismatches = 0;
  int comparisons = 0;
  int cyc = 0;
  int pos[13] = '{19, 13, 12, 10, 9, 8, 7, 6, 5, 4, 3, 2, 0};
  bsf_top u_bsf_top (.ref_clk, .rst_n, .reg_addr, .reg_byte_sel, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .reg_err, .revision_id(8'hA3), .src_valid, .src_code,
    .thermal_shutdown_reboot(ev[0]), .r1_crc_fail(ev[1]), .r0_crc_fail(ev[2]),
    .patch_dl_error(ev[3]), .r1_read_error(ev[4]), .r0_read_error(ev[5]),
    .r1_header_invalid(ev[6]), .r0_header_invalid(ev[7]), .r1_attempted(ev[8]),
    .r0_attempted(ev[9]), .eeprom_present(ev[10]), .dead_battery_boot(ev[11]),
    .patch_header_error(ev[12]), .status_q);
  initial forever #12.5 ref_clk = ~ref_clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    comparisons++;
    if (got !== want) begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask : chk
  task automatic rd(input logic [2:0] s, input logic [7:0] a, input logic [7:0] w, input logic e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_byte_sel <= s;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, w);
    chk({7'h00, reg_err}, {7'h00, e});
  endtask : rd
  task automatic rd40();
    for (int s = 0; s < 5; s++) begin
      rd(3'(s), BSF_ADDR_STATUS, exp_q[s*8 +: 8], 1'b0);
      // Full image output must agree with the byte view
      chk(status_q[s*8 +: 8], exp_q[s*8 +: 8]);
    end
  endtask : rd40
  task automatic src(input bsf_src_type c);
    @(posedge ref_clk);
    src_code <= c;
    src_valid <= 1'b1;
    @(posedge ref_clk);
    src_valid <= 1'b0;
  endtask : src
  task automatic tally_and_finish();
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  // =============================
  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    exp_q = {8'hA3, 32'h0};
    rd40();
    for (int i = 0; i < 13; i++) begin
      @(posedge ref_clk);
      ev <= 13'h0001 << i;
      @(posedge ref_clk);
      ev <= 13'h0000;
      exp_q[pos[i]] = 1'b1;
      // Earlier flags must still read set
      rd40();
    end
    src(BSF_SRC_EEPROM);
    rd(3'h3, BSF_ADDR_STATUS, 8'hA0, 1'b0);
    src(bsf_src_type'(3'h7));
    rd(3'h3, BSF_ADDR_STATUS, 8'hA0, 1'b0);
    src(BSF_SRC_I2C);
    rd(3'h3, BSF_ADDR_STATUS, 8'hC0, 1'b0);
    src(BSF_SRC_NONE);
    @(posedge ref_clk);
    reg_addr <= BSF_ADDR_STATUS;
    reg_wdata <= 8'hFF;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    rd(3'h0, 8'h2C, 8'h00, 1'b1);
    rd(3'h5, BSF_ADDR_STATUS, 8'h00, 1'b1);
    rd40();
    tally_and_finish();
  end
  // Hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      mismatches++;
      tally_and_finish();
    end
  end
endmodule : bsf_top_tb_top
`default_nettype wire
